// ==== design/pwc_map.svh ====
// Constants of the pulse width and edge separation counter.
// Assumes one 40 MHz system clock; included by bare name.
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH
// Widths
`define PWC_CNT_W 32
`define PWC_PIN_N 4
`define PWC_SEL_W 2
`define PWC_TBS_W 3
`define PWC_FIFO_DEPTH 4
// Clock figures, nominal internal timebase
`define PWC_SYS_HZ 40000000
`define PWC_TB_INT_HZ 100000000
// Edge select: 0 rising (default), 1 falling
`define PWC_EDGE_RISE 1'b0
`define PWC_EDGE_FALL 1'b1
// Arm trigger type: 0 none, 1 digital edge
`define PWC_ARM_NONE 1'b0
`define PWC_ARM_EDGE 1'b1
// Timebase select: bit 2 set picks a pin, else the internal clock
`define PWC_TB_INTERNAL 3'h0
`define PWC_TB_EXT_BIT 2
`endif

// ==== design/pwc_pkg.sv ====
// Types of the pulse width and edge separation counter.
// Assumes pwc_map.svh holds the numeric constants.
package pwc_pkg;
  typedef enum logic [1:0] {
    PWC_MEAS_WIDTH = 2'h0,
    PWC_MEAS_SEP = 2'h1,
    PWC_MEAS_PERIOD = 2'h2
  } pwc_meas_e;
  typedef enum logic [1:0] {
    PWC_TM_ON_DEMAND = 2'h0,
    PWC_TM_IMPLICIT = 2'h1,
    PWC_TM_SAMPLE = 2'h2
  } pwc_timing_e;
  typedef enum logic [2:0] {
    PWC_ST_IDLE = 3'h0,
    PWC_ST_WAIT_ARM = 3'h1,
    PWC_ST_WAIT_START = 3'h2,
    PWC_ST_COUNT = 3'h3,
    PWC_ST_HOLD = 3'h4
  } pwc_state_e;
endpackage : pwc_pkg

// ==== design/pwc_fifo_if.sv ====
// Result stream between the counter core and its buffer.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`include "pwc_map.svh"
interface pwc_fifo_if;
  logic push_valid;
  logic push_ready;
  logic [`PWC_CNT_W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [`PWC_CNT_W-1:0] pop_data;
  logic flush;
  modport src (output push_valid, push_data, pop_ready, flush,
               input push_ready, pop_valid, pop_data);
  modport buf_end (input push_valid, push_data, pop_ready, flush,
                   output push_ready, pop_valid, pop_data);
endinterface : pwc_fifo_if

// ==== design/pwc_fifo.sv ====
// Small flip-flop FIFO holding measurement results.
// Assumes a single clock and synchronous flush.
`timescale 1ns/1ps
module pwc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Stream ends
  pwc_fifo_if.buf_end fi
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  // Handshakes; full and empty come from the occupancy count
  assign fi.push_ready = (cnt_q != DEPTH[AW:0]);
  assign fi.pop_valid = (cnt_q != '0);
  assign fi.pop_data = mem_q[rd_q];
  assign do_push = fi.push_valid && fi.push_ready;
  assign do_pop = fi.pop_ready && fi.pop_valid;

  // Storage, written by index
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem_q[wr_q] <= fi.push_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (fi.flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end
endmodule : pwc_fifo

// ==== design/pwc_counter.sv ====
// Pulse width, edge separation and period counter with result buffer.
// Assumes asynchronous pins and configuration held steady while running.
// What this block does
// - Count timebase edges while input is active.
// - Width starts only on transition into active.
// - Default measures high pulse, rise to fall.
// - Start edge selectable; opposite edge ends.
// - On-demand width held until read, then next.
// - Implicit width: pulses buffered, read in order; a newer one overwrites a stalled one when full.
// - Sample clock stores last complete width.
// - Arm trigger edge starts counting instead.
// - Partial pulse at arm trigger is skipped.
// - Timebase internal by default, else selectable.
// - Separation counts first edge to second edge.
// - Both edges default rising, independently selectable.
// - On-demand separation held until read.
// - Implicit separation: pairs buffered; a newer one overwrites a stalled one when full.
// - Sample clock stores last complete separation.
// - Separation uses the same selectable timebase.
// - Period measured like frequency, own input select.
`timescale 1ns/1ps
`include "pwc_map.svh"
module pwc_counter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Asynchronous input pins
  input wire logic [`PWC_PIN_N-1:0] programmable_input_pin,
  // Configuration
  input wire pwc_pkg::pwc_meas_e meas_mode,
  input wire pwc_pkg::pwc_timing_e timing_mode,
  input wire logic [`PWC_SEL_W-1:0] width_input_select,
  input wire logic width_start_edge,
  input wire logic [`PWC_SEL_W-1:0] sep_first_input_select,
  input wire logic [`PWC_SEL_W-1:0] sep_second_input_select,
  input wire logic sep_first_edge,
  input wire logic sep_second_edge,
  input wire logic [`PWC_SEL_W-1:0] period_input_select,
  input wire logic [`PWC_TBS_W-1:0] timebase_select,
  input wire logic [`PWC_SEL_W-1:0] sample_clock_select,
  input wire logic arm_trigger_type,
  input wire logic [`PWC_SEL_W-1:0] arm_trigger_source,
  input wire logic arm_trigger_edge,
  // Commands, one-cycle pulses
  input wire logic start,
  input wire logic stop,
  input wire logic read_req,
  // Results and status
  output logic rd_valid,
  output logic [`PWC_CNT_W-1:0] rd_data,
  output logic result_ready,
  output logic overflow,
  output logic running
);
  pwc_fifo_if fif ();
  pwc_pkg::pwc_state_e state_q;
  logic [`PWC_PIN_N-1:0] s1_q, s2_q, s3_q, lvl_q, prev_q;
  logic [`PWC_CNT_W-1:0] count_q, held_q, last_q, push_data_q, rd_data_q;
  logic last_ok_q, push_valid_q, rd_valid_q, ovf_q, ready_q, running_q;
  logic tb_tick, begin_ev, end_ev, arm_ev, smp_ev, new_push, buffered;

  // Edge of one filtered pin; falling selects the falling edge
  function automatic logic edge_hit(input logic [`PWC_PIN_N-1:0] lvl,
                                    input logic [`PWC_PIN_N-1:0] prv,
                                    input logic [`PWC_SEL_W-1:0] idx,
                                    input logic falling);
    logic rise;
    logic fall;
    rise = lvl[idx] & ~prv[idx];
    fall = ~lvl[idx] & prv[idx];
    edge_hit = (falling == `PWC_EDGE_FALL) ? fall : rise;
  endfunction : edge_hit

  //////////////////////////////////////////////////////////////////////////
  // Three-stage pin synchroniser; level moves once stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= programmable_input_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered level and its previous value for edge detection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lvl_q <= '0;
      prev_q <= '0;
    end else begin
      lvl_q <= (s3_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
      prev_q <= lvl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event decode
  always_comb begin
    // timebase source select
    // Internal timebase ticks every cycle; a pin timebase counts rising edges
    if (timebase_select[`PWC_TB_EXT_BIT]) begin
      tb_tick = edge_hit(lvl_q, prev_q, timebase_select[`PWC_SEL_W-1:0],
                         `PWC_EDGE_RISE);
    end else begin
      tb_tick = 1'b1;
    end
    case (meas_mode)
      pwc_pkg::PWC_MEAS_WIDTH: begin
        begin_ev = edge_hit(lvl_q, prev_q, width_input_select, width_start_edge);
        end_ev = edge_hit(lvl_q, prev_q, width_input_select, ~width_start_edge);
      end
      pwc_pkg::PWC_MEAS_SEP: begin
        begin_ev = edge_hit(lvl_q, prev_q, sep_first_input_select, sep_first_edge);
        end_ev = edge_hit(lvl_q, prev_q, sep_second_input_select, sep_second_edge);
      end
      pwc_pkg::PWC_MEAS_PERIOD: begin
        begin_ev = edge_hit(lvl_q, prev_q, period_input_select, `PWC_EDGE_RISE);
        end_ev = begin_ev;
      end
      default: begin
        begin_ev = 1'b0;
        end_ev = 1'b0;
      end
    endcase
    arm_ev = edge_hit(lvl_q, prev_q, arm_trigger_source, arm_trigger_edge);
    smp_ev = edge_hit(lvl_q, prev_q, sample_clock_select, `PWC_EDGE_RISE);
  end

  assign buffered = (timing_mode != pwc_pkg::PWC_TM_ON_DEMAND);

  //////////////////////////////////////////////////////////////////////////
  // Control state machine
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= pwc_pkg::PWC_ST_IDLE;
      running_q <= 1'b0;
    end else if (stop) begin
      state_q <= pwc_pkg::PWC_ST_IDLE;
      running_q <= 1'b0;
    end else if (start) begin
      running_q <= 1'b1;
      state_q <= (arm_trigger_type == `PWC_ARM_EDGE) ?
                 pwc_pkg::PWC_ST_WAIT_ARM : pwc_pkg::PWC_ST_WAIT_START;
    end else begin
      case (state_q)
        pwc_pkg::PWC_ST_IDLE: begin
          state_q <= pwc_pkg::PWC_ST_IDLE;
        end
        pwc_pkg::PWC_ST_WAIT_ARM: begin
          if (arm_ev) begin
            state_q <= pwc_pkg::PWC_ST_WAIT_START;
          end
        end
        pwc_pkg::PWC_ST_WAIT_START: begin
          if (begin_ev) begin
            state_q <= pwc_pkg::PWC_ST_COUNT;
          end
        end
        pwc_pkg::PWC_ST_COUNT: begin
          if (end_ev) begin
            if (!buffered) begin
              state_q <= pwc_pkg::PWC_ST_HOLD;
            end else if (meas_mode != pwc_pkg::PWC_MEAS_PERIOD) begin
              state_q <= pwc_pkg::PWC_ST_WAIT_START;
            end
          end
        end
        pwc_pkg::PWC_ST_HOLD: begin
          if (read_req) begin
            state_q <= pwc_pkg::PWC_ST_WAIT_START;
          end
        end
        default: begin
          state_q <= pwc_pkg::PWC_ST_IDLE;
          running_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (start || stop) begin
      count_q <= '0;
    end else if (state_q == pwc_pkg::PWC_ST_WAIT_START && begin_ev) begin
      count_q <= '0;
    end else if (state_q == pwc_pkg::PWC_ST_COUNT) begin
      // Period restarts on its ending edge so no pulse is missed
      if (end_ev) begin
        count_q <= '0;
      end else if (tb_tick) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      held_q <= '0;
    end else if (state_q == pwc_pkg::PWC_ST_COUNT && end_ev && !buffered) begin
      held_q <= count_q;
    end
  end

  // latest complete result for sample-clock timing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_q <= '0;
      last_ok_q <= 1'b0;
    end else if (start || stop) begin
      last_ok_q <= 1'b0;
    end else if (state_q == pwc_pkg::PWC_ST_COUNT && end_ev) begin
      last_q <= count_q;
      last_ok_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // every result pushed in implicit mode
  // every pair pushed in implicit mode
  assign new_push = (start || stop) ? 1'b0 :
    (timing_mode == pwc_pkg::PWC_TM_IMPLICIT) ?
      (state_q == pwc_pkg::PWC_ST_COUNT && end_ev) :
    (timing_mode == pwc_pkg::PWC_TM_SAMPLE) ?
      (smp_ev && last_ok_q && state_q != pwc_pkg::PWC_ST_IDLE) : 1'b0;

  // Push register waits for room; a newer result overwrites a stalled one
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      push_valid_q <= 1'b0;
      push_data_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (start) begin
        push_valid_q <= 1'b0;
      end else if (new_push) begin
        push_valid_q <= 1'b1;
        push_data_q <= (timing_mode == pwc_pkg::PWC_TM_SAMPLE) ? last_q : count_q;
      end else if (fif.push_ready) begin
        push_valid_q <= 1'b0;
      end
      // A clearing start wins over overflow set; no result is pushed in a start cycle
      if (new_push && push_valid_q && !fif.push_ready) begin
        ovf_q <= 1'b1;
      end else if (start) begin
        ovf_q <= 1'b0;
      end
    end
  end

  assign fif.push_valid = push_valid_q;
  assign fif.push_data = push_data_q;
  assign fif.pop_ready = read_req && buffered;
  assign fif.flush = start;

  pwc_fifo #(
    .WIDTH(`PWC_CNT_W),
    .DEPTH(`PWC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .fi(fif)
  );

  // Read answer: held value or oldest buffered value
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      ready_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      if (read_req && !buffered && state_q == pwc_pkg::PWC_ST_HOLD) begin
        rd_valid_q <= 1'b1;
        rd_data_q <= held_q;
      end else if (fif.pop_ready && fif.pop_valid) begin
        rd_valid_q <= 1'b1;
        rd_data_q <= fif.pop_data;
      end
      ready_q <= buffered ? fif.pop_valid : (state_q == pwc_pkg::PWC_ST_HOLD);
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign result_ready = ready_q;
  assign overflow = ovf_q;
  assign running = running_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_idle_stays;
    state_q == pwc_pkg::PWC_ST_IDLE && !start |=> state_q == pwc_pkg::PWC_ST_IDLE;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("left idle without start");
  property p_count_tick;
    state_q == pwc_pkg::PWC_ST_COUNT && tb_tick && !end_ev && !start && !stop
      |=> count_q == $past(count_q) + 1'b1;
  endproperty
  a_count_tick: assert property (p_count_tick) else $error("tick not counted");
  property p_no_begin;
    state_q == pwc_pkg::PWC_ST_WAIT_START && !begin_ev && !start && !stop
      |=> state_q == pwc_pkg::PWC_ST_WAIT_START;
  endproperty
  a_no_begin: assert property (p_no_begin) else $error("began without edge");
  property p_high_pulse;
    state_q == pwc_pkg::PWC_ST_WAIT_START && meas_mode == pwc_pkg::PWC_MEAS_WIDTH &&
      width_start_edge == `PWC_EDGE_RISE && lvl_q[width_input_select] &&
      !prev_q[width_input_select] && !start && !stop
      |=> state_q == pwc_pkg::PWC_ST_COUNT ##0 count_q == '0;
  endproperty
  a_high_pulse: assert property (p_high_pulse) else $error("rise did not start");
  property p_hold;
    state_q == pwc_pkg::PWC_ST_HOLD && !read_req && !start && !stop
      |=> state_q == pwc_pkg::PWC_ST_HOLD && $stable(held_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold not kept");
  property p_hold_read;
    state_q == pwc_pkg::PWC_ST_HOLD && read_req && !buffered && !start && !stop
      |=> rd_valid && rd_data == $past(held_q) && state_q == pwc_pkg::PWC_ST_WAIT_START;
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("held read wrong");
  property p_impl_push;
    timing_mode == pwc_pkg::PWC_TM_IMPLICIT && state_q == pwc_pkg::PWC_ST_COUNT &&
      end_ev && !start && !stop |=> push_valid_q && push_data_q == $past(count_q);
  endproperty
  a_impl_push: assert property (p_impl_push) else $error("result not pushed");
  property p_smp_push;
    timing_mode == pwc_pkg::PWC_TM_SAMPLE && smp_ev && last_ok_q &&
      state_q != pwc_pkg::PWC_ST_IDLE && !start && !stop
      |=> push_valid_q && push_data_q == $past(last_q);
  endproperty
  a_smp_push: assert property (p_smp_push) else $error("sample not stored");
  property p_arm_wait;
    state_q == pwc_pkg::PWC_ST_WAIT_ARM && !arm_ev && !start && !stop
      |=> state_q == pwc_pkg::PWC_ST_WAIT_ARM;
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("armed without trigger");
  property p_arm_go;
    state_q == pwc_pkg::PWC_ST_WAIT_ARM && arm_ev && !start && !stop
      |=> state_q == pwc_pkg::PWC_ST_WAIT_START;
  endproperty
  a_arm_go: assert property (p_arm_go) else $error("trigger not taken");

  c_hold: cover property (state_q == pwc_pkg::PWC_ST_COUNT ##1
                          state_q == pwc_pkg::PWC_ST_HOLD);
  c_push: cover property (push_valid_q && fif.push_ready);
  c_full: cover property (push_valid_q && !fif.push_ready);
  c_arm: cover property (state_q == pwc_pkg::PWC_ST_WAIT_ARM ##1
                         state_q == pwc_pkg::PWC_ST_WAIT_START);
endmodule : pwc_counter

// ==== test/pwc_sig_model.sv ====
// Model of the external signals feeding the counter pins.
// Assumes the bench calls its tasks from falling clock edges.
`timescale 1ns/1ps
`include "pwc_map.svh"
module pwc_sig_model (
  // Clock
  input wire logic clk_sys,
  // Driven pins
  output logic [`PWC_PIN_N-1:0] pin
);
  // All pins low until told otherwise
  initial begin
    pin = 4'h0;
  end

  //////////////////////////////////////////////////////////////////////
  // Settle time covers the three-flop synchroniser with margin
  task automatic set_pin(input int idx, input logic v);
    pin[idx] = v;
    repeat (6) @(negedge clk_sys);
  endtask : set_pin

  // active edge, then ending edge d cycles later
  task automatic event_pair(input logic sep, input int a, input logic e0, input logic e1,
                            input int d);
    pin[a] = ~e0;
    repeat (d) @(negedge clk_sys);
    if (sep) begin
      pin[1] = ~e1;
      repeat (6) @(negedge clk_sys);
      pin[1] = e1;
    end
    pin[a] = e0;
    repeat (6) @(negedge clk_sys);
  endtask : event_pair

  // pulse on pin 0 holding n rising edges of a slow pin 3 timebase
  task automatic ticked_pulse(input int n);
    pin[3] = 1'b0;
    pin[0] = 1'b1;
    repeat (6) @(negedge clk_sys);
    repeat (n) begin
      pin[3] = 1'b1;
      repeat (4) @(negedge clk_sys);
      pin[3] = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    pin[0] = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask : ticked_pulse
endmodule : pwc_sig_model

// ==== test/tb.sv ====
// Self-checking bench for the pulse width and separation counter.
// Assumes internal timebase, one tick per cycle, except the pin timebase case.
`timescale 1ns/1ps
`include "pwc_map.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [`PWC_PIN_N-1:0] pins;
  pwc_pkg::pwc_meas_e meas_mode = pwc_pkg::PWC_MEAS_WIDTH;
  pwc_pkg::pwc_timing_e timing_mode = pwc_pkg::PWC_TM_ON_DEMAND;
  logic [1:0] in_sel = 2'h0;
  logic [2:0] tb_sel = `PWC_TB_INTERNAL;
  logic w_edge = 1'b0;
  logic f_edge = 1'b0;
  logic s_edge = 1'b0;
  logic arm_type = `PWC_ARM_NONE;
  logic arm_edge = `PWC_EDGE_RISE;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic read_req = 1'b0;
  logic rd_valid, result_ready, overflow, running;
  logic [`PWC_CNT_W-1:0] rd_data;
  logic [7:0] rnd_q = 8'h22;
  logic [`PWC_CNT_W-1:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int c, k, d, d1, a;
  logic m, e0, e1;

  // Clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;

  pwc_counter dut (.clk_sys(clk_sys), .rstn(rstn), .programmable_input_pin(pins),
    .meas_mode(meas_mode), .timing_mode(timing_mode), .width_input_select(in_sel),
    .width_start_edge(w_edge), .sep_first_input_select(in_sel),
    .sep_second_input_select(2'h1), .sep_first_edge(f_edge), .sep_second_edge(s_edge),
    .period_input_select(in_sel), .timebase_select(tb_sel),
    .sample_clock_select(2'h2), .arm_trigger_type(arm_type), .arm_trigger_source(2'h2),
    .arm_trigger_edge(arm_edge), .start(start), .stop(stop), .read_req(read_req),
    .rd_valid(rd_valid), .rd_data(rd_data), .result_ready(result_ready),
    .overflow(overflow), .running(running));

  pwc_sig_model sig (.clk_sys(clk_sys), .pin(pins));

  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Lengths of at least 4 cycles so the synchroniser never drops one
  task automatic next_len(output int n);
    rnd_q = lfsr(rnd_q);
    n = 4 + int'(rnd_q[3:0]);
  endtask : next_len

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Stop first: changing config while running is undefined
  task automatic setup(input logic sep, input pwc_pkg::pwc_timing_e tm);
    stop = 1'b1;
    @(negedge clk_sys);
    stop = 1'b0;
    meas_mode = sep ? pwc_pkg::PWC_MEAS_SEP : pwc_pkg::PWC_MEAS_WIDTH;
    timing_mode = tm;
    @(negedge clk_sys);
  endtask : setup

  task automatic go();
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    chk("running", 32'h1, {31'h0, running});
  endtask : go

  task automatic read_one(input logic want, input logic [31:0] exp);
    int i;
    logic seen;
    seen = 1'b0;
    read_req = 1'b1;
    @(negedge clk_sys);
    read_req = 1'b0;
    for (i = 0; i < 3 && !seen; i++) begin
      if (rd_valid === 1'b1) seen = 1'b1;
      else @(negedge clk_sys);
    end
    chk("rd_valid", {31'h0, want}, {31'h0, seen});
    if (want && seen) chk("rd_data", exp, rd_data);
    @(negedge clk_sys);
  endtask : read_one

  task automatic wait_rdy();
    int i;
    for (i = 0; i < 300 && result_ready !== 1'b1; i++) @(negedge clk_sys);
    chk("result_ready", 32'h1, {31'h0, result_ready});
    if (result_ready !== 1'b1) give_verdict();
  endtask : wait_rdy

  //////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    #1000000;
    chk("run_time", 32'h0, 32'h1);
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (3) @(negedge clk_sys);
    chk("running", 32'h0, {31'h0, running});
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("outputs", 32'h0, {28'h0, rd_valid, result_ready, overflow, running});
    for (c = 0; c < 6; c++) begin
      m = (c >= 2);
      e0 = c[0];
      e1 = c[1] & m;
      a = c[0] ? 3 : 0;
      setup(m, pwc_pkg::PWC_TM_ON_DEMAND);
      in_sel = a[1:0];
      w_edge = e0;
      f_edge = e0;
      s_edge = e1;
      sig.set_pin(1, e1);
      sig.set_pin(a, ~e0);
      go();
      sig.set_pin(a, e0);
      next_len(d1);
      sig.event_pair(m, a, e0, e1, d1);
      wait_rdy();
      next_len(d);
      sig.event_pair(m, a, e0, e1, d);
      read_one(1'b1, 32'(d1 - 1));
      next_len(d);
      sig.event_pair(m, a, e0, e1, d);
      wait_rdy();
      read_one(1'b1, 32'(d - 1));
      read_one(1'b0, 32'h0);
    end
    in_sel = 2'h0;
    w_edge = 1'b0;
    f_edge = 1'b0;
    s_edge = 1'b0;
    sig.set_pin(0, 1'b0);
    sig.set_pin(1, 1'b0);
    for (c = 0; c < 2; c++) begin
      setup(c[0], pwc_pkg::PWC_TM_IMPLICIT);
      go();
      exp_q.delete();
      for (k = 0; k < 6; k++) begin
        next_len(d);
        sig.event_pair(c[0], 0, 1'b0, 1'b0, d);
        if (k != 4) exp_q.push_back(32'(d - 1));
      end
      chk("overflow", 32'h1, {31'h0, overflow});
      for (k = 0; k < 5; k++) read_one(1'b1, exp_q.pop_front());
      read_one(1'b0, 32'h0);
    end
    // sample clock keeps the latest complete result
    for (c = 0; c < 2; c++) begin
      setup(c[0], pwc_pkg::PWC_TM_SAMPLE);
      go();
      next_len(d);
      sig.event_pair(c[0], 0, 1'b0, 1'b0, d);
      next_len(d);
      sig.event_pair(c[0], 0, 1'b0, 1'b0, d);
      for (k = 0; k < 2; k++) begin
        sig.set_pin(2, 1'b1);
        sig.set_pin(2, 1'b0);
        wait_rdy();
        read_one(1'b1, 32'(d - 1));
      end
    end
    // period rise to rise, on-demand then gapless implicit
    for (c = 0; c < 2; c++) begin
      setup(1'b0, c[0] ? pwc_pkg::PWC_TM_IMPLICIT : pwc_pkg::PWC_TM_ON_DEMAND);
      meas_mode = pwc_pkg::PWC_MEAS_PERIOD;
      go();
      exp_q.delete();
      for (k = 0; k < 3; k++) begin
        next_len(d);
        sig.event_pair(1'b0, 0, 1'b0, 1'b0, d);
        if (k < 2) exp_q.push_back(32'(d + 5));
      end
      wait_rdy();
      for (k = 0; k < (c[0] ? 2 : 1); k++) read_one(1'b1, exp_q.pop_front());
    end
    // pin timebase counts its rising edges during the pulse
    setup(1'b0, pwc_pkg::PWC_TM_ON_DEMAND);
    tb_sel = 3'h7;
    go();
    next_len(d);
    sig.ticked_pulse(d);
    wait_rdy();
    read_one(1'b1, 32'(d));
    tb_sel = `PWC_TB_INTERNAL;
    // arm trigger on either edge, partial pulse skipped
    arm_type = `PWC_ARM_EDGE;
    for (c = 0; c < 2; c++) begin
      setup(1'b0, pwc_pkg::PWC_TM_ON_DEMAND);
      arm_edge = c[0];
      sig.set_pin(2, c[0]);
      go();
      sig.event_pair(1'b0, 0, 1'b0, 1'b0, 7);
      sig.set_pin(0, 1'b1);
      sig.set_pin(2, ~c[0]);
      sig.set_pin(0, 1'b0);
      chk("result_ready", 32'h0, {31'h0, result_ready});
      next_len(d);
      sig.event_pair(1'b0, 0, 1'b0, 1'b0, d);
      wait_rdy();
      read_one(1'b1, 32'(d - 1));
    end
    setup(1'b0, pwc_pkg::PWC_TM_ON_DEMAND);
    chk("running", 32'h0, {31'h0, running});
    give_verdict();
  end
endmodule : tb
